/* File: core/sfcf_regs.vh */
// Constants for the serial flash command framer: opcodes, widths, states
`ifndef SFCF_REGS_VH
`define SFCF_REGS_VH

// ---------------------------------------------------------------
// Framer states
// ---------------------------------------------------------------
`define SFCF_ST_IDLE      3'h0
`define SFCF_ST_INSTR     3'h1
`define SFCF_ST_ADDR      3'h2
`define SFCF_ST_MODE      3'h3
`define SFCF_ST_HDR       3'h4
`define SFCF_ST_DUMMY     3'h5
`define SFCF_ST_RDATA     3'h6
`define SFCF_ST_WDATA     3'h7

// ---------------------------------------------------------------
// Widths and field positions
// ---------------------------------------------------------------
`define SFCF_W1           3'h1
`define SFCF_W2           3'h2
`define SFCF_W4           3'h4
`define SFCF_BYTE_BITS    4'h8
`define SFCF_ADDR3        3'h3
`define SFCF_ADDR4        3'h4
`define SFCF_ADDR_LEN_BIT 7
`define SFCF_ADDR_LEN_RST 1'h0
`define SFCF_CONT_NIB     4'hA

// ---------------------------------------------------------------
// Always four-byte address opcodes
// ---------------------------------------------------------------
`define SFCF_OP_RD4       8'h13
`define SFCF_OP_QRD4      8'h0C
`define SFCF_OP_DIO4      8'hBC
`define SFCF_OP_QIO4      8'hEC
`define SFCF_OP_DQIO4     8'hEE
`define SFCF_OP_PGW4      8'h12
`define SFCF_OP_SER4      8'h21
`define SFCF_OP_BLK4      8'hDC
`define SFCF_OP_ECC4      8'h18
`define SFCF_OP_DYR4      8'hE0
`define SFCF_OP_DYW4      8'hE1
`define SFCF_OP_PPR4      8'hE2
`define SFCF_OP_PPW4      8'hE3

// ---------------------------------------------------------------
// Opcodes whose address length follows the volatile bit
// ---------------------------------------------------------------
`define SFCF_OP_RD        8'h03
`define SFCF_OP_QRD       8'h0B
`define SFCF_OP_DIO       8'hBB
`define SFCF_OP_QIO       8'hEB
`define SFCF_OP_DQIO      8'hED
`define SFCF_OP_PGW       8'h02
`define SFCF_OP_SER       8'h20
`define SFCF_OP_BLK       8'hD8
`define SFCF_OP_ANYRD     8'h65
`define SFCF_OP_ANYWR     8'h71
`define SFCF_OP_ECHK      8'hD0
`define SFCF_OP_OTPW      8'h42
`define SFCF_OP_ONE_TIME_AREA_READ      8'h4B
`define SFCF_OP_ECC       8'h19
`define SFCF_OP_DYR       8'hFA
`define SFCF_OP_DYW       8'hFB
`define SFCF_OP_PPR       8'hFC
`define SFCF_OP_PPW       8'hFD

// ---------------------------------------------------------------
// Commands still taken while an internal operation runs
// ---------------------------------------------------------------
`define SFCF_OP_STAT1     8'h05
`define SFCF_OP_STAT2     8'h07

`endif

/* File: core/sfcf_cmd_decode.v */
// Instruction classifier: phase widths, address length and command kind
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.vh"

module sfcf_cmd_decode (
	// Instruction and mode inputs
	input  wire [7:0] i_code,
	input  wire       i_qpi,
	input  wire       i_addr_len,
	// Classification
	output reg  [2:0] o_width,
	output reg  [2:0] o_addr_bytes,
	output reg        o_has_mode,
	output reg        o_is_read,
	output reg        o_use_dummy,
	output reg        o_busy_ok
);

	// ---------------------------------------------------------------
	// Decode table
	// ---------------------------------------------------------------
	// Unknown codes fall through as bare single-width commands
	always @* begin
		o_width      = `SFCF_W1;
		o_addr_bytes = 3'h0;
		o_has_mode   = 1'b0;
		o_is_read    = 1'b0;
		o_use_dummy  = 1'b0;
		o_busy_ok    = 1'b0;
		case (i_code)
			`SFCF_OP_RD4, `SFCF_OP_ECC4, `SFCF_OP_DYR4, `SFCF_OP_PPR4: begin
				o_addr_bytes = `SFCF_ADDR4; // [RL19]
				o_is_read    = 1'b1;
			end
			`SFCF_OP_QRD4: begin
				o_addr_bytes = `SFCF_ADDR4; // [RL19]
				o_is_read    = 1'b1;
				o_use_dummy  = 1'b1;
			end
			`SFCF_OP_DIO4: begin
				o_width      = `SFCF_W2; // [RL3]
				o_addr_bytes = `SFCF_ADDR4; // [RL19]
				o_has_mode   = 1'b1;
				o_is_read    = 1'b1;
				o_use_dummy  = 1'b1;
			end
			`SFCF_OP_QIO4, `SFCF_OP_DQIO4: begin
				o_width      = `SFCF_W4; // [RL3]
				o_addr_bytes = `SFCF_ADDR4; // [RL19]
				o_has_mode   = 1'b1;
				o_is_read    = 1'b1;
				o_use_dummy  = 1'b1;
			end
			`SFCF_OP_PGW4, `SFCF_OP_SER4, `SFCF_OP_BLK4, `SFCF_OP_DYW4, `SFCF_OP_PPW4: begin
				o_addr_bytes = `SFCF_ADDR4; // [RL19]
			end
			`SFCF_OP_RD, `SFCF_OP_ECC, `SFCF_OP_DYR, `SFCF_OP_PPR, `SFCF_OP_ONE_TIME_AREA_READ,
			`SFCF_OP_ANYRD: begin
				o_addr_bytes = i_addr_len ? `SFCF_ADDR4 : `SFCF_ADDR3; // [RL20] [RL22]
				o_is_read    = 1'b1;
			end
			`SFCF_OP_QRD: begin
				o_addr_bytes = i_addr_len ? `SFCF_ADDR4 : `SFCF_ADDR3; // [RL22]
				o_is_read    = 1'b1;
				o_use_dummy  = 1'b1;
			end
			`SFCF_OP_DIO: begin
				o_width      = `SFCF_W2; // [RL3] [RL8]
				o_addr_bytes = i_addr_len ? `SFCF_ADDR4 : `SFCF_ADDR3; // [RL22]
				o_has_mode   = 1'b1;
				o_is_read    = 1'b1;
				o_use_dummy  = 1'b1;
			end
			`SFCF_OP_QIO, `SFCF_OP_DQIO: begin
				o_width      = `SFCF_W4; // [RL3] [RL8]
				o_addr_bytes = i_addr_len ? `SFCF_ADDR4 : `SFCF_ADDR3; // [RL22]
				o_has_mode   = 1'b1;
				o_is_read    = 1'b1;
				o_use_dummy  = 1'b1;
			end
			`SFCF_OP_PGW, `SFCF_OP_SER, `SFCF_OP_BLK, `SFCF_OP_ANYWR, `SFCF_OP_ECHK,
			`SFCF_OP_OTPW, `SFCF_OP_DYW, `SFCF_OP_PPW: begin
				o_addr_bytes = i_addr_len ? `SFCF_ADDR4 : `SFCF_ADDR3; // [RL20] [RL22]
			end
			`SFCF_OP_STAT1, `SFCF_OP_STAT2: begin
				o_is_read    = 1'b1;
				o_busy_ok    = 1'b1; // [RL14]
			end
			default: begin
				o_width      = `SFCF_W1;
			end
		endcase
		// All-quad mode overrides every phase width
		if (i_qpi) begin
			o_width = `SFCF_W4; // [RL4]
		end
	end

endmodule
`default_nettype wire

/* File: core/sfcf_framer.v */
// Serial flash command framer: pin sampling, phase sequencing, data shifting
//
// Overview of operation
// (RL1) Command opens with one instruction byte
// (RL2) Single width: input on IO0, output on IO1
// (RL3) Dual/quad IO: instruction single, rest wide
// (RL4) All-quad mode: every phase four bits wide
// (RL5) Continuous read starts at address, reuses instruction
// (RL6) Mode bits after address select continuous read
// (RL7) Address is three or four bytes
// (RL8) Instruction code selects later phase widths
// (RL9) Lowest bit on IO0, MSB first
// (RL10) Optional dummy cycles before read data
// (RL11) All fields move in whole bytes
// (RL12) Address arrives most significant byte first
// (RL13) Data address increments per byte
// (RL14) Busy: ignore array reads, allow few
// (RL15) Host polls busy flag before commands
// (RL16) Host drives select/clock; device drives read
// (RL17) Select low frames command; high ends it
// (RL18) Flag commands ending off byte boundary
// (RL19) Listed opcodes always take four address bytes
// (RL20) Length bit set forces four-byte legacy commands
// (RL21) Reload length bit from nonvolatile at reset
// (RL22) Length bit switches listed opcodes three/four
// (RL23) Abandon partial header when select rises
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.vh"

module sfcf_framer (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// Flash pins (sampled from outside the clock domain)
	input  wire        i_sck,
	input  wire        i_cs_n,
	input  wire [3:0]  i_io,
	output reg  [3:0]  o_io_out,
	output reg  [3:0]  o_io_oe,
	// Configuration and status from the device core
	input  wire        i_all_quad_mode,
	input  wire        i_addr_len_nv,
	input  wire        i_soft_reset,
	input  wire        i_addr_len_wr,
	input  wire        i_addr_len_wdata,
	input  wire        i_write_in_progress_flag,
	input  wire [4:0]  i_dummy_cycles,
	input  wire [7:0]  i_rd_data,
	// Decoded command towards the device core
	output reg         o_cmd_valid,
	output reg  [7:0]  o_cmd_code,
	output reg  [31:0] o_cmd_addr,
	output reg         o_cmd_end,
	output reg         o_cmd_bad,
	output reg  [31:0] o_data_addr,
	output reg  [7:0]  o_wr_data,
	output reg         o_wr_valid,
	output reg         o_cont_read,
	output reg         o_addr_len,
	output reg         o_busy_reject
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	wire [5:0] pin_raw = {i_sck, i_cs_n, i_io};
	reg  [5:0] meta_r;          // First stage, read only by second stage
	reg  [5:0] sync_r;          // Second stage, safe to use
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_sync
			// Two flops per pin; select idles high so it resets high
			always @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					meta_r[g] <= (g == 4) ? 1'b1 : 1'b0;
					sync_r[g] <= (g == 4) ? 1'b1 : 1'b0;
				end else begin
					meta_r[g] <= pin_raw[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	wire       sck_s  = sync_r[5];
	wire       cs_s   = sync_r[4];
	wire [3:0] io_s   = sync_r[3:0];
	reg        sck_d_r;         // Previous clock level for edge finding
	wire       sck_rise = sck_s & ~sck_d_r;
	wire       sck_fall = ~sck_s & sck_d_r;

	// ---------------------------------------------------------------
	// Framer state
	// ---------------------------------------------------------------
	reg [2:0]  state_r;         // Current phase
	reg [7:0]  code_r;          // Instruction of the running command
	reg [7:0]  sr_r;            // Input shift register
	reg [2:0]  bitcnt_r;        // Bits gathered in the current byte
	reg [2:0]  bytecnt_r;       // Address bytes gathered
	reg [31:0] addr_r;          // Address being assembled
	reg [4:0]  dcnt_r;          // Dummy cycles seen
	reg [7:0]  out_sr_r;        // Output shift register
	reg [3:0]  ocnt_r;          // Bits presented from out_sr_r
	reg        drive_r;         // Device owns the data lines
	reg        len_load_r;      // Pending reload of the length bit
	reg        hdr_seen_r;      // Header finished in this frame

	// ---------------------------------------------------------------
	// Decoder
	// ---------------------------------------------------------------
	wire [2:0] dec_width;
	wire [2:0] dec_abytes;
	wire       dec_mode;
	wire       dec_read;
	wire       dec_dummy;
	wire       dec_busy_ok;

	sfcf_cmd_decode u_dec (
		.i_code       (code_r),
		.i_qpi        (i_all_quad_mode),
		.i_addr_len   (o_addr_len),
		.o_width      (dec_width),
		.o_addr_bytes (dec_abytes),
		.o_has_mode   (dec_mode),
		.o_is_read    (dec_read),
		.o_use_dummy  (dec_dummy),
		.o_busy_ok    (dec_busy_ok)
	);

	// Instruction width is one bit except in all-quad mode
	wire [2:0] iw = i_all_quad_mode ? `SFCF_W4 : `SFCF_W1; // [RL3] [RL4]
	// Width of the phase now being received
	wire [2:0] pw = (state_r == `SFCF_ST_INSTR) ? iw : dec_width; // [RL8]

	// Shift in one group; IO0 carries the least significant bit
	reg [7:0] shifted;
	always @* begin
		case (pw)
			`SFCF_W2: shifted = {sr_r[5:0], io_s[1:0]}; // [RL9]
			`SFCF_W4: shifted = {sr_r[3:0], io_s[3:0]}; // [RL9]
			default:  shifted = {sr_r[6:0], io_s[0]};   // [RL2]
		endcase
	end

	wire [3:0] bits_next = {1'b0, bitcnt_r} + {1'b0, pw};
	wire       byte_done = (bits_next == `SFCF_BYTE_BITS); // [RL11]
	wire [31:0] addr_full = {addr_r[23:0], shifted}; // [RL12]

	// ---------------------------------------------------------------
	// Address length bit
	// ---------------------------------------------------------------
	// Reset only arms a reload; the strap is caught after release
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			len_load_r <= 1'b1;
			o_addr_len <= `SFCF_ADDR_LEN_RST;
		end else begin
			len_load_r <= i_soft_reset;
			if (len_load_r) begin
				o_addr_len <= i_addr_len_nv; // [RL21]
			end else if (i_addr_len_wr) begin
				o_addr_len <= i_addr_len_wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Phase sequencer
	// ---------------------------------------------------------------
	// Input side acts on clock rises, output side on clock falls
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sck_d_r       <= 1'b0;
			state_r       <= `SFCF_ST_IDLE;
			code_r        <= 8'h00;
			sr_r          <= 8'h00;
			bitcnt_r      <= 3'h0;
			bytecnt_r     <= 3'h0;
			addr_r        <= 32'h0000_0000;
			dcnt_r        <= 5'h00;
			out_sr_r      <= 8'h00;
			ocnt_r        <= 4'h0;
			drive_r       <= 1'b0;
			hdr_seen_r    <= 1'b0;
			o_cmd_valid   <= 1'b0;
			o_cmd_code    <= 8'h00;
			o_cmd_addr    <= 32'h0000_0000;
			o_cmd_end     <= 1'b0;
			o_cmd_bad     <= 1'b0;
			o_data_addr   <= 32'h0000_0000;
			o_wr_data     <= 8'h00;
			o_wr_valid    <= 1'b0;
			o_cont_read   <= 1'b0;
			o_busy_reject <= 1'b0;
		end else begin
			sck_d_r     <= sck_s;
			o_cmd_valid <= 1'b0;
			o_cmd_end   <= 1'b0;
			o_wr_valid  <= 1'b0;
			if (cs_s) begin
				// Select high ends any frame in progress
				if (state_r != `SFCF_ST_IDLE) begin
					o_cmd_end <= 1'b1; // [RL17]
					// Partial header or broken byte: core must discard
					o_cmd_bad <= ~hdr_seen_r | (bitcnt_r != 3'h0); // [RL18] [RL23]
				end
				state_r <= `SFCF_ST_IDLE;
				drive_r <= 1'b0;
			end else begin
				case (state_r)
					`SFCF_ST_IDLE: begin
						// Select low opens a frame
						bitcnt_r      <= 3'h0;
						bytecnt_r     <= 3'h0;
						addr_r        <= 32'h0000_0000;
						dcnt_r        <= 5'h00;
						ocnt_r        <= 4'h0;
						hdr_seen_r    <= 1'b0;
						o_cmd_bad     <= 1'b0;
						o_busy_reject <= 1'b0;
						if (o_cont_read) begin
							state_r <= `SFCF_ST_ADDR; // [RL5]
						end else begin
							state_r <= `SFCF_ST_INSTR; // [RL1]
						end
					end
					`SFCF_ST_INSTR: begin
						if (sck_rise) begin
							sr_r     <= shifted;
							bitcnt_r <= bits_next[2:0];
							if (byte_done) begin
								code_r <= shifted; // [RL1]
								state_r <= `SFCF_ST_ADDR;
							end
						end
					end
					`SFCF_ST_ADDR: begin
						// Zero-length address goes straight on
						if (dec_abytes == 3'h0) begin
							state_r <= `SFCF_ST_HDR;
						end else if (sck_rise) begin
							sr_r     <= shifted;
							bitcnt_r <= bits_next[2:0];
							if (byte_done) begin
								addr_r    <= addr_full; // [RL12]
								bytecnt_r <= bytecnt_r + 3'h1;
								if (bytecnt_r + 3'h1 == dec_abytes) begin // [RL7]
									state_r <= dec_mode ? `SFCF_ST_MODE : `SFCF_ST_HDR;
								end
							end
						end
					end
					`SFCF_ST_MODE: begin
						if (sck_rise) begin
							sr_r     <= shifted;
							bitcnt_r <= bits_next[2:0];
							if (byte_done) begin
								// Mode nibble decides whether the next frame skips its opcode
								o_cont_read <= (shifted[7:4] == `SFCF_CONT_NIB); // [RL6]
								state_r     <= `SFCF_ST_HDR;
							end
						end
					end
					`SFCF_ST_HDR: begin
						// One clock between the last header rise and the next fall
						hdr_seen_r  <= 1'b1;
						if (i_write_in_progress_flag && !dec_busy_ok) begin
							// Busy: swallow the frame, leave the running operation alone
							o_busy_reject <= 1'b1; // [RL14]
							o_cont_read   <= 1'b0;
							state_r       <= `SFCF_ST_WDATA;
						end else begin
							// Address only moves for accepted commands
							o_data_addr <= addr_r;
							o_cmd_valid <= 1'b1;
							o_cmd_code  <= code_r;
							o_cmd_addr  <= addr_r;
							if (!dec_read) begin
								state_r <= `SFCF_ST_WDATA;
							end else if (dec_dummy && i_dummy_cycles != 5'h00) begin
								state_r <= `SFCF_ST_DUMMY; // [RL10]
							end else begin
								state_r <= `SFCF_ST_RDATA;
							end
						end
					end
					`SFCF_ST_DUMMY: begin
						if (sck_rise) begin
							dcnt_r <= dcnt_r + 5'h01;
							if (dcnt_r + 5'h01 == i_dummy_cycles) begin
								state_r <= `SFCF_ST_RDATA; // [RL10]
							end
						end
					end
					`SFCF_ST_RDATA: begin
						// New bits go out on falls so they settle before the host samples
						if (sck_fall) begin
							drive_r <= 1'b1; // [RL16]
							if (ocnt_r == 4'h0 || ocnt_r == `SFCF_BYTE_BITS) begin
								out_sr_r    <= i_rd_data;
								ocnt_r      <= {1'b0, dec_width};
								o_data_addr <= o_data_addr + 32'h0000_0001; // [RL13]
							end else begin
								out_sr_r <= out_sr_r << dec_width; // [RL9]
								ocnt_r   <= ocnt_r + {1'b0, dec_width};
							end
						end
					end
					`SFCF_ST_WDATA: begin
						// Incoming data bytes; rejected frames shift but never report
						if (sck_rise) begin
							sr_r     <= shifted;
							bitcnt_r <= bits_next[2:0];
							if (byte_done && !o_busy_reject) begin
								o_wr_data  <= shifted; // [RL11]
								o_wr_valid <= 1'b1;
								dcnt_r     <= 5'h01; // Idle in write frames; marks a byte taken
							end
							if (byte_done && hdr_seen_r && !o_busy_reject && dcnt_r != 5'h00) begin
								o_data_addr <= o_data_addr + 32'h0000_0001; // [RL13]
							end
						end
					end
					default: begin
						state_r <= `SFCF_ST_IDLE;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	// Registered so every pin output comes straight from a flop
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_io_out <= 4'h0;
			o_io_oe  <= 4'h0;
		end else if (!drive_r || cs_s) begin
			o_io_out <= 4'h0;
			o_io_oe  <= 4'h0; // [RL16]
		end else begin
			case (dec_width)
				`SFCF_W4: begin
					o_io_out <= out_sr_r[7:4]; // [RL9]
					o_io_oe  <= 4'hF;
				end
				`SFCF_W2: begin
					o_io_out <= {2'h0, out_sr_r[7:6]}; // [RL9]
					o_io_oe  <= 4'h3;
				end
				default: begin
					o_io_out <= {2'h0, out_sr_r[7], 1'b0}; // [RL2]
					o_io_oe  <= 4'h2;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: testbench/sfcf_framer_monitor.sv */
// Port-level concurrent checks for the command framer
`timescale 1ns/1ps
`default_nettype none

module sfcf_framer_monitor (
	// Clock, reset and inputs
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_cs_n,
	input wire logic        i_all_quad_mode,
	input wire logic        i_addr_len_nv,
	input wire logic        i_soft_reset,
	input wire logic        i_addr_len_wr,
	input wire logic        i_addr_len_wdata,
	// Framer outputs
	input wire logic [3:0]  o_io_oe,
	input wire logic        o_cmd_valid,
	input wire logic [7:0]  o_cmd_code,
	input wire logic        o_cmd_end,
	input wire logic        o_cmd_bad,
	input wire logic [31:0] o_data_addr,
	input wire logic        o_wr_valid,
	input wire logic        o_cont_read,
	input wire logic        o_busy_reject,
	input wire logic        o_addr_len
);
	// ------------------------------------------------
	// Assertions on the system clock
	// ------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	AST_OE_SHAPE: assert property (o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("bad enable pattern");
	AST_QUAD_ALL: assert property (i_all_quad_mode && o_io_oe != 4'h0 |-> o_io_oe == 4'hF)
		else $error("narrow drive in all-quad");
	// Six cycles cover sync plus output flop
	AST_OE_IDLE: assert property (i_cs_n [*6] |-> o_io_oe == 4'h0)
		else $error("driven while deselected");
	AST_VALID_SEL: assert property (o_cmd_valid |-> !i_cs_n ##1 !o_cmd_valid)
		else $error("valid outside frame or held");
	AST_END_SEL: assert property (o_cmd_end |-> i_cs_n)
		else $error("end while selected");
	AST_BUSY: assert property (o_busy_reject |-> !o_cmd_valid && !o_wr_valid)
		else $error("busy frame made traffic");
	AST_BAD_END: assert property ($rose(o_cmd_bad) |-> o_cmd_end)
		else $error("bad flag off frame end");
	AST_LEN_RELOAD: assert property (i_soft_reset |=> ##1 o_addr_len == $past(i_addr_len_nv, 2))
		else $error("no length reload");
	AST_LEN_WR: assert property (i_addr_len_wr && !i_soft_reset |=> o_addr_len == $past(i_addr_len_wdata))
		else $error("no length write");
	AST_ADDR_STEP: assert property (!$stable(o_data_addr) && !o_cmd_valid |-> o_data_addr == $past(o_data_addr) + 32'h1)
		else $error("address step not one");
	AST_CODE_HOLD: assert property (!o_cmd_valid |-> $stable(o_cmd_code))
		else $error("code moved without command");

	// Scenarios
	cover property (o_cmd_valid && o_cont_read);
	cover property (o_busy_reject);
	cover property (o_cmd_bad && o_cmd_end);
	cover property (o_wr_valid);
endmodule

`default_nettype wire

/* File: testbench/sfcf_host_model.sv */
// Host controller model: select, serial clock and IO lines
`timescale 1ns/1ps
`default_nettype none

module sfcf_host_model (
	// Lines as seen on the board
	input  wire logic [3:0] i_io,
	// Lines the host drives
	output var logic        o_sck,
	output var logic        o_cs_n,
	output var logic [3:0]  o_io,
	output var logic [3:0]  o_io_en
);
	// Idle levels
	initial begin
		o_sck   = 1'b0;
		o_cs_n  = 1'b1;
		o_io    = 4'h0;
		o_io_en = 4'h0;
	end

	// Select before first rise
	task automatic start();
		o_cs_n = 1'b0;
		#100;
	endtask

	// Deselect, then a gap
	task automatic stop();
		#100 o_cs_n = 1'b1;
		o_io_en = 4'h0;
		#200;
	endtask

	// w-bit groups, MSB first, IO0 lowest; reads sampled late high
	task automatic xfer(input logic [31:0] v, input int nb, input int w, input bit rd, output logic [31:0] got);
		int k;
		got = 32'h0;
		for (k = nb - w; k >= 0; k -= w) begin
			o_io_en = rd ? 4'h0 : 4'((1 << w) - 1);
			o_io    = 4'(v >> k);
			#62.5 o_sck = 1'b1;
			#60 got = (got << w) | (w == 1 ? 32'(i_io[1]) : 32'(i_io) & ((1 << w) - 1));
			#2.5 o_sck = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

/* File: testbench/sfcf_framer_test.sv */
// Self-checking bench for the serial flash command framer
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.vh"

module sfcf_framer_test;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic        i_clk, i_rst, sck, cs_n, pat;
	logic [3:0]  hio, hen, out, oe;
	wire  [3:0]  io;
	logic        i_all_quad_mode, i_addr_len_nv, i_soft_reset, i_addr_len_wr, i_addr_len_wdata, i_wip;
	logic [4:0]  i_dummy_cycles;
	logic [7:0]  i_rd_data, o_cmd_code, o_wr_data;
	logic [31:0] o_cmd_addr, o_data_addr;
	logic        o_cmd_valid, o_cmd_end, o_cmd_bad, o_wr_valid, o_cont_read, o_addr_len, o_busy_reject;
	int          n_mismatch, n_compared, cyc;
	logic [39:0] cq[$];
	logic [7:0]  wq[$];
	logic [7:0]  codes[31] = '{8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hED, 8'h02, 8'h20, 8'hD8, 8'h65, 8'h71, 8'hD0,
		8'h42, 8'h4B, 8'h19, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'h13, 8'h0C, 8'hBC, 8'hEC, 8'hEE, 8'h12, 8'h21,
		8'hDC, 8'h18, 8'hE0, 8'hE1, 8'hE2, 8'hE3};

	// Released lines toggle
	assign io = (oe & out) | (~oe & hen & hio) | (~oe & ~hen & {4{pat}});
	// Memory: byte from address
	assign i_rd_data = o_data_addr[7:0] ^ 8'h5A;
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) pat <= ~pat;

	sfcf_host_model sfcf_host_model_i (.i_io(io), .o_sck(sck), .o_cs_n(cs_n), .o_io(hio), .o_io_en(hen));
	sfcf_framer sfcf_framer_i (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_io(io),
		.o_io_out(out), .o_io_oe(oe), .i_all_quad_mode(i_all_quad_mode), .i_addr_len_nv(i_addr_len_nv),
		.i_soft_reset(i_soft_reset), .i_addr_len_wr(i_addr_len_wr), .i_addr_len_wdata(i_addr_len_wdata),
		.i_write_in_progress_flag(i_wip), .i_dummy_cycles(i_dummy_cycles), .i_rd_data(i_rd_data),
		.o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code), .o_cmd_addr(o_cmd_addr), .o_cmd_end(o_cmd_end),
		.o_cmd_bad(o_cmd_bad), .o_data_addr(o_data_addr), .o_wr_data(o_wr_data), .o_wr_valid(o_wr_valid),
		.o_cont_read(o_cont_read), .o_addr_len(o_addr_len), .o_busy_reject(o_busy_reject));

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	function automatic logic [7:0] f(input logic [31:0] x);
		return x[7:0] ^ 8'h5A;
	endfunction

	// Opcode phase width
	function automatic int wid(input logic [7:0] c);
		case (c)
			8'hBB, 8'hBC: return 2;
			8'hEB, 8'hEC, 8'hED, 8'hEE: return 4;
			default: return 1;
		endcase
	endfunction

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Header; wi 0 = implied opcode
	task automatic cmd(input logic [7:0] c, input logic [31:0] a, input int na, input int wi, input int wa,
		input bit mb, input logic [7:0] m, input bit ex);
		logic [31:0] g;
		if (ex)
			cq.push_back({c, na == 4 ? a : {8'h00, a[23:0]}});
		sfcf_host_model_i.start();
		if (wi > 0)
			sfcf_host_model_i.xfer(32'(c), 8, wi, 1'b0, g);
		sfcf_host_model_i.xfer(a, na * 8, wa, 1'b0, g);
		if (mb)
			sfcf_host_model_i.xfer(32'(m), 8, wa, 1'b0, g);
	endtask

	// Length write or soft reset
	task automatic ctl(input logic wr, input logic sr, input logic d);
		@(posedge i_clk);
		#1 {i_addr_len_wr, i_soft_reset, i_addr_len_wdata} = {wr, sr, d};
		@(posedge i_clk);
		#1 {i_addr_len_wr, i_soft_reset} = 2'b00;
		repeat (3) @(posedge i_clk);
	endtask

	// ------------------------------------------------
	// Watcher and timeout
	// ------------------------------------------------
	always @(posedge i_clk) begin
		if (o_cmd_valid === 1'b1)
			check({o_cmd_code, o_cmd_addr}, cq.size() ? cq.pop_front() : 40'hFFFFFFFFFF);
		if (o_wr_valid === 1'b1)
			check(40'(o_wr_data), wq.size() ? 40'(wq.pop_front()) : 40'h100);
	end

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		logic [31:0] g, a, d;
		int i;
		{i_clk, i_rst, pat, cyc, n_mismatch, n_compared} = {3'b010, 96'h0};
		{i_all_quad_mode, i_soft_reset, i_addr_len_wr, i_addr_len_wdata, i_wip} = 5'h00;
		i_addr_len_nv = 1'b1;
		i_dummy_cycles = 5'h00;
		void'($urandom(32'hFB8894AE));
		repeat (5) @(posedge i_clk);
		#1 i_rst = 1'b0;
		repeat (3) @(posedge i_clk);
		check(40'(o_addr_len), 40'h1);
		// Single read, length bit set
		a = $urandom;
		cmd(`SFCF_OP_RD, a, 4, 1, 1, 1'b0, 8'h00, 1'b1);
		sfcf_host_model_i.xfer(32'h0, 16, 1, 1'b1, g);
		check(40'(g[15:0]), {f(a), f(a + 1)});
		sfcf_host_model_i.stop();
		ctl(1'b1, 1'b0, 1'b0);
		check(40'(o_addr_len), 40'h0);
		// Every listed opcode
		for (i = 0; i < 31; i++) begin
			cmd(codes[i], $urandom, i < 18 ? 3 : 4, 1, wid(codes[i]), wid(codes[i]) > 1, 8'h00, 1'b1);
			sfcf_host_model_i.stop();
		end
		// Page write
		a = $urandom;
		d = $urandom;
		cmd(`SFCF_OP_PGW, a, 3, 1, 1, 1'b0, 8'h00, 1'b1);
		wq.push_back(d[15:8]);
		wq.push_back(d[7:0]);
		sfcf_host_model_i.xfer(d, 16, 1, 1'b0, g);
		sfcf_host_model_i.stop();
		// Quad read arms, implied repeat disarms
		@(posedge i_clk);
		#1 i_dummy_cycles = 5'h04;
		for (i = 0; i < 2; i++) begin
			a = $urandom;
			cmd(`SFCF_OP_QIO, a, 3, 1 - i, 4, 1'b1, i ? 8'h00 : 8'hA0, 1'b1);
			sfcf_host_model_i.xfer(32'h0, 16, 4, 1'b1, d);
			sfcf_host_model_i.xfer(32'h0, 16, 4, 1'b1, g);
			check(40'(g[15:0]), {f(a), f(a + 1)});
			check(40'(o_cont_read), 40'(1 - i));
			sfcf_host_model_i.stop();
		end
		// All-quad mode
		@(posedge i_clk);
		#1 {i_all_quad_mode, i_dummy_cycles} = 6'h20;
		a = $urandom;
		cmd(`SFCF_OP_RD, a, 3, 4, 4, 1'b0, 8'h00, 1'b1);
		sfcf_host_model_i.xfer(32'h0, 8, 4, 1'b1, g);
		check(40'(g[7:0]), 40'(f(a)));
		sfcf_host_model_i.stop();
		// Busy refusal
		@(posedge i_clk);
		#1 {i_all_quad_mode, i_wip} = 2'b01;
		cmd(`SFCF_OP_RD, $urandom, 3, 1, 1, 1'b0, 8'h00, 1'b0);
		check(40'(o_busy_reject), 40'h1);
		sfcf_host_model_i.stop();
		@(posedge i_clk);
		#1 i_wip = 1'b0;
		// Cut address
		sfcf_host_model_i.start();
		sfcf_host_model_i.xfer(32'h03, 8, 1, 1'b0, g);
		sfcf_host_model_i.xfer($urandom, 12, 1, 1'b0, g);
		sfcf_host_model_i.stop();
		check(40'(o_cmd_bad), 40'h1);
		// Soft reset reload
		ctl(1'b0, 1'b1, 1'b0);
		check(40'(o_addr_len), 40'h1);
		repeat (10) @(posedge i_clk);
		check(40'(cq.size() + wq.size()), 40'h0);
		print_verdict();
	end
endmodule

bind sfcf_framer sfcf_framer_monitor sfcf_framer_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
	.i_all_quad_mode(i_all_quad_mode), .i_addr_len_nv(i_addr_len_nv), .i_soft_reset(i_soft_reset),
	.i_addr_len_wr(i_addr_len_wr), .i_addr_len_wdata(i_addr_len_wdata), .o_io_oe(o_io_oe),
	.o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code), .o_cmd_end(o_cmd_end), .o_cmd_bad(o_cmd_bad),
	.o_data_addr(o_data_addr), .o_wr_valid(o_wr_valid), .o_cont_read(o_cont_read),
	.o_busy_reject(o_busy_reject), .o_addr_len(o_addr_len));

`default_nettype wire
